// file: design/reset_source_and_cause_logic.sv
// Reset source combiner, pin filter, brown-out modes and reset cause flags
`timescale 1ns/1ps

// Function
// - Low external pin holds hard reset
// - Pin filter discards short glitches
// - Internal resets never drive the pin
// - Supply rise while armed gives power-on reset
// - Power-on reset clears power-on flag
// - Only software sets power-on flag
// - Four brown-out modes from two-bit field
// - Supply below selected level resets device, except in zero-power mode
// - Every brown-out event re-arms power-on detector
// - Zero-power drop only re-arms, reset held until supply rises
// - Brown-out and power-on resets clear brown-out flag
// - Low-power brown-out leaves brown-out flag alone
module reset_source_and_cause_logic #(
   parameter int FILT_CYC = rst_cause_pkg::FILTER_CYC  // Pin filter length
) (
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              rstn_i,
   // External reset pin, input only
   input  wire logic                              external_reset_pin_n_i,
   output logic                                   external_reset_pin_o,
   output logic                                   external_reset_pin_oe_o,
   // Supply monitors
   input  wire logic                              supply_above_por_i,
   input  wire logic [3:0]                        supply_below_level_i,
   input  wire logic                              supply_below_zero_i,
   // Configuration words
   input  wire logic [7:0]                        config_word_two_low_i,
   input  wire logic [7:0]                        config_word_one_low_i,
   // Register port
   input  wire logic [rst_cause_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [rst_cause_pkg::DATA_W-1:0]  wdata_i,
   input  wire logic                              wr_i,
   input  wire logic                              rd_i,
   output logic      [rst_cause_pkg::DATA_W-1:0]  rdata_o,
   // Core reset and interrupt
   output logic                                   core_reset_n_o,
   output logic                                   irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0]                  brownout_power_select;  // Mode field
   logic [1:0]                  brownout_level_select;  // Trip level field
   logic                        brownout_below;         // Selected level tripped
   logic                        zero_power_brownout_mode;
   logic                        low_power_brownout;
   logic [7:0]                  filt_cnt_reg;           // Pin low run length
   logic                        pin_low_reg;            // Filtered pin level
   logic                        por_armed_reg;          // Waiting for supply rise
   logic                        por_event;              // Power-on reset pulse
   logic                        bor_event_reg;          // Brown-out edge tracker
   logic                        bor_event;              // Brown-out reset pulse
   logic                        zp_prev_reg;            // Zero-power edge tracker
   logic                        rearm_event;            // Re-arm pulse
   logic                        pin_event;              // Filtered pin fall
   logic                        any_src;                // Any source active
   logic                        power_on_flag_reg;
   logic                        brownout_flag_reg;
   logic [rst_cause_pkg::EV_W-1:0] status_reg;
   logic [rst_cause_pkg::EV_W-1:0] mask_reg;
   logic [rst_cause_pkg::EV_W-1:0] events;
   logic [rst_cause_pkg::EV_W-1:0] sources;
   // Cause flag values after reset
   localparam logic CAUSE_POR_RST =
      rst_cause_pkg::CAUSE_RESET_VAL[rst_cause_pkg::CAUSE_POR_BIT];
   localparam logic CAUSE_BOR_RST =
      rst_cause_pkg::CAUSE_RESET_VAL[rst_cause_pkg::CAUSE_BOR_BIT];

   // Write strobe decode for one offset
   function automatic logic wr_hit(input logic [3:0] off);
      return wr_i && (addr_i == off);
   endfunction

   // ----------------------------------------------------------------
   // Pin and mode decode
   // ----------------------------------------------------------------
   // pin never driven
   assign external_reset_pin_o     = 1'b0;
   assign external_reset_pin_oe_o  = 1'b0;

   assign brownout_power_select    =
      config_word_two_low_i[rst_cause_pkg::PWR_SEL_LSB +: 2];
   assign brownout_level_select    =
      config_word_one_low_i[rst_cause_pkg::LVL_SEL_LSB +: 2];
   assign zero_power_brownout_mode = (brownout_power_select == rst_cause_pkg::PWR_ZERO);
   assign low_power_brownout       = (brownout_power_select == rst_cause_pkg::PWR_LOW);

   // selected trip level, ignored in zero-power mode
   assign brownout_below = !zero_power_brownout_mode &&
                           supply_below_level_i[brownout_level_select];

   // ----------------------------------------------------------------
   // External pin glitch filter
   // ----------------------------------------------------------------
   // low must persist FILT_CYC cycles
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         filt_cnt_reg <= 8'h00;
      end else if (external_reset_pin_n_i) begin
         filt_cnt_reg <= 8'h00;
      end else if (filt_cnt_reg < 8'(FILT_CYC)) begin
         filt_cnt_reg <= filt_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_low_reg <= 1'b0;
      end else begin
         pin_low_reg <= !external_reset_pin_n_i &&
                        (filt_cnt_reg >= 8'(FILT_CYC - 1));
      end
   end

   // Filtered pin fall, in the cycle the filter completes
   assign pin_event = !external_reset_pin_n_i && !pin_low_reg &&
                      (filt_cnt_reg >= 8'(FILT_CYC - 1));

   // ----------------------------------------------------------------
   // Brown-out and re-arm edges
   // ----------------------------------------------------------------
   // Edge trackers for the two supply monitors
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bor_event_reg <= 1'b0;
         zp_prev_reg   <= 1'b0;
      end else begin
         bor_event_reg <= brownout_below;
         zp_prev_reg   <= zero_power_brownout_mode && supply_below_zero_i;
      end
   end

   // Rising edge of the selected trip level
   assign bor_event   = brownout_below && !bor_event_reg;
   assign rearm_event = bor_event ||
                        (zero_power_brownout_mode && supply_below_zero_i && !zp_prev_reg);

   // ----------------------------------------------------------------
   // Power-on detector
   // ----------------------------------------------------------------
   // armed from reset, fires on supply rise
   assign por_event = por_armed_reg && supply_above_por_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         por_armed_reg <= 1'b1;
      end else if (rearm_event) begin
         por_armed_reg <= 1'b1;
      end else if (por_event) begin
         por_armed_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Reset cause flags
   // ----------------------------------------------------------------
   // power-on clears flag, hardware clear beats software set
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_on_flag_reg <= CAUSE_POR_RST;
      end else if (por_event) begin
         power_on_flag_reg <= 1'b0;
      end else if (wr_hit(rst_cause_pkg::CAUSE_OFFSET)) begin
         // only a software write changes it otherwise
         power_on_flag_reg <= wdata_i[rst_cause_pkg::CAUSE_POR_BIT];
      end
   end

   // cleared by brown-out and power-on, low-power exempt
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         brownout_flag_reg <= CAUSE_BOR_RST;
      end else if (por_event || (bor_event && !low_power_brownout)) begin
         brownout_flag_reg <= 1'b0;
      end else if (wr_hit(rst_cause_pkg::CAUSE_OFFSET)) begin
         brownout_flag_reg <= wdata_i[rst_cause_pkg::CAUSE_BOR_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Combined core reset
   // ----------------------------------------------------------------
   // Re-armed detector counts as an active source until the supply rises
   assign any_src = pin_low_reg || pin_event || brownout_below || por_armed_reg;

   // released on a clock edge once all sources drop
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_reset_n_o <= 1'b0;
      end else begin
         core_reset_n_o <= !any_src;
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and interrupt
   // ----------------------------------------------------------------
   assign events  = {rearm_event, pin_event, bor_event, por_event};
   assign sources = {por_armed_reg, pin_low_reg, brownout_below, !core_reset_n_o};

   // Sticky status, set wins over write-one-to-clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_reg <= 4'h0;
      end else begin
         status_reg <= events |
            (status_reg & ~(wr_hit(rst_cause_pkg::STATUS_OFFSET) ? wdata_i[3:0] : 4'h0));
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_reg <= rst_cause_pkg::MASK_RESET_VAL;
      end else if (wr_hit(rst_cause_pkg::MASK_OFFSET)) begin
         mask_reg <= wdata_i[3:0];
      end
   end

   assign irq_o = |(status_reg & mask_reg);

   // ----------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------------
   // both flags read together in one word
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            rst_cause_pkg::CAUSE_OFFSET:  rdata_o <= {6'h00, power_on_flag_reg,
                                                       brownout_flag_reg};
            rst_cause_pkg::STATUS_OFFSET: rdata_o <= {4'h0, status_reg};
            rst_cause_pkg::MASK_OFFSET:   rdata_o <= {4'h0, mask_reg};
            rst_cause_pkg::SOURCE_OFFSET: rdata_o <= {4'h0, sources};
            default:                      rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_pin_never_driven: assert property (!external_reset_pin_oe_o)
      else $error("reset pin output enable raised");
   a_pin_low_holds: assert property (pin_low_reg |=> !core_reset_n_o)
      else $error("filtered pin low did not hold reset");
   a_glitch_ignored: assert property (
      (external_reset_pin_n_i ##1 !external_reset_pin_n_i ##1 external_reset_pin_n_i)
      |-> !pin_low_reg && !$past(pin_low_reg))
      else $error("one cycle pin glitch caused reset");
   a_por_clears_flag: assert property (por_event |=> !power_on_flag_reg)
      else $error("power-on flag not cleared");
   a_por_flag_sw_only: assert property ($rose(power_on_flag_reg) |->
      $past(wr_i) && ($past(addr_i) == rst_cause_pkg::CAUSE_OFFSET))
      else $error("power-on flag set without software write");
   a_bor_resets: assert property ($rose(brownout_below) |=> !core_reset_n_o)
      else $error("brown-out did not reset core");
   a_bor_rearms: assert property (bor_event |=> por_armed_reg)
      else $error("brown-out did not re-arm power-on detector");
   a_zero_no_reset: assert property (
      zero_power_brownout_mode && !por_armed_reg && !pin_low_reg && !pin_event
      && !$past(por_armed_reg) |=> core_reset_n_o || $past(por_armed_reg))
      else $error("zero-power mode caused reset");
   a_bor_flag_clear: assert property (
      bor_event && !low_power_brownout |=> !brownout_flag_reg)
      else $error("brown-out flag not cleared");
   a_low_keeps_flag: assert property (
      low_power_brownout && brownout_flag_reg && !por_event
      && !(wr_i && addr_i == rst_cause_pkg::CAUSE_OFFSET) |=> brownout_flag_reg)
      else $error("low-power brown-out changed flag");
   a_sync_release: assert property (!any_src ##1 !any_src |-> core_reset_n_o)
      else $error("core reset not released");
   a_por_disarms: assert property (por_event && !rearm_event |=> !por_armed_reg)
      else $error("power-on event left detector armed");
   a_por_clears_bor: assert property (por_event |=> !brownout_flag_reg)
      else $error("power-on did not clear brown-out flag");

   c_power_on: cover property (por_event ##[1:20] core_reset_n_o);
   c_pin_reset: cover property (pin_event ##1 !core_reset_n_o);
   c_brownout: cover property (bor_event ##[1:50] por_event);
   c_irq: cover property ($rose(irq_o));
   c_zero_rearm: cover property (zero_power_brownout_mode && rearm_event);

endmodule

// file: pkg/rst_cause_pkg.sv
// Constants shared by the reset source and cause logic
package rst_cause_pkg;
   // -----------------------------------------------------------------
   // Register bus layout
   // -----------------------------------------------------------------
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam logic [3:0]  CAUSE_OFFSET    = 4'h0;  // Reset cause flags
   localparam logic [3:0]  STATUS_OFFSET   = 4'h1;  // Sticky event status
   localparam logic [3:0]  MASK_OFFSET     = 4'h2;  // Interrupt mask
   localparam logic [3:0]  SOURCE_OFFSET   = 4'h3;  // Live reset sources
   // Cause register fields
   localparam int          CAUSE_BOR_BIT   = 0;     // Brown-out flag
   localparam int          CAUSE_POR_BIT   = 1;     // Power-on flag
   localparam logic [1:0]  CAUSE_RESET_VAL = 2'h0;
   // Status / mask fields, source bit 0 is core reset active
   localparam int          EV_POR_BIT      = 0;     // Power-on reset
   localparam int          EV_BOR_BIT      = 1;     // Brown-out reset
   localparam int          EV_PIN_BIT      = 2;     // External pin reset
   localparam int          EV_REARM_BIT    = 3;     // Power-on detector re-armed
   localparam int          EV_W            = 4;
   localparam logic [3:0]  MASK_RESET_VAL  = 4'h0;
   // -----------------------------------------------------------------
   // Configuration word fields
   // -----------------------------------------------------------------
   localparam int          PWR_SEL_LSB     = 5;     // Word two low bits 6:5
   localparam int          LVL_SEL_LSB     = 2;     // Word one low bits 3:2
   localparam logic [1:0]  PWR_HIGH        = 2'h0;
   localparam logic [1:0]  PWR_MEDIUM      = 2'h1;
   localparam logic [1:0]  PWR_LOW         = 2'h2;
   localparam logic [1:0]  PWR_ZERO        = 2'h3;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_PERIOD_PS   = 5000;  // 200 MHz
   localparam int          FILTER_NS       = 20;    // Least pin low time
   localparam int          FILTER_CYC      =
      ((FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
      (FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// file: sim/supply_and_pin_model.sv
// Far-side model: external reset pin driver and supply voltage monitors
`timescale 1ns/1ps

module supply_and_pin_model #(
   parameter int POR_MV  = 1500,  // Power-on detector threshold in mV
   parameter int ZERO_MV = 2000   // Zero-power re-arm point in mV
) (
   // Commands from the bench
   input  wire logic        pin_low_req_i,
   input  wire logic [15:0] supply_mv_i,
   // Pin pull-down request, the line is pulled up otherwise
   output logic             pin_pull_low_o,
   // Supply monitor outputs
   output logic             supply_above_por_o,
   output logic [3:0]       supply_below_level_o,
   output logic             supply_below_zero_o
);
   // Trip points for level select codes 0 to 3
   localparam int TRIP_MV [4] = '{1800, 2000, 2700, 3000};

   // -----------------------------------------------------------------
   // Pin driver
   // -----------------------------------------------------------------
   // pin pulled low
   assign pin_pull_low_o = pin_low_req_i;

   // -----------------------------------------------------------------
   // Supply comparators
   // -----------------------------------------------------------------
   // threshold comparisons
   always_comb begin
      supply_above_por_o  = (int'(supply_mv_i) > POR_MV);
      supply_below_zero_o = (int'(supply_mv_i) < ZERO_MV);
      for (int n = 0; n < 4; n++) begin
         supply_below_level_o[n] = (int'(supply_mv_i) < TRIP_MV[n]);
      end
   end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the reset source and cause logic
`timescale 1ns/1ps

module testbench;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam int FILT = 4;                        // Pin filter length
   localparam int TRIP_MV [4] = '{1800, 2000, 2700, 3000};
   typedef struct { string name; logic [7:0] exp; logic [7:0] care; } note_t;
   logic        clk_i, rstn_i, wr_i, rd_i, rd_seen;
   logic [3:0]  addr_i;
   logic [7:0]  wdata_i, rdata_o, cfg2, cfg1, rnd;
   logic        pin_low_req, pin_pull_low, pin_out, pin_oe, pin_n;
   logic [15:0] supply_mv;
   logic        above_por, below_zero, core_reset_n_o, irq_o;
   logic [3:0]  below_level;
   note_t       notes_q[$];                       // Expected read results
   note_t       note;
   int          errors, n_compared, g, h;

   // Resolved pin level: pull-up unless someone pulls low
   assign pin_n = ~(pin_pull_low | (pin_oe & ~pin_out));

   supply_and_pin_model i_model (.pin_low_req_i(pin_low_req), .supply_mv_i(supply_mv),
      .pin_pull_low_o(pin_pull_low), .supply_above_por_o(above_por),
      .supply_below_level_o(below_level), .supply_below_zero_o(below_zero));

   reset_source_and_cause_logic #(.FILT_CYC(FILT)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .external_reset_pin_n_i(pin_n), .external_reset_pin_o(pin_out),
      .external_reset_pin_oe_o(pin_oe), .supply_above_por_i(above_por),
      .supply_below_level_i(below_level), .supply_below_zero_i(below_zero),
      .config_word_two_low_i(cfg2), .config_word_one_low_i(cfg1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .core_reset_n_o(core_reset_n_o), .irq_o(irq_o));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Clock at 200 MHz
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      if (errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One bus cycle, strobes stay up until the next bus, rd or idle call, or a direct clear
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= w;
      rd_i    <= ~w;
   endtask

   task automatic idle();
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] c,
                     input string name);
      notes_q.push_back('{name, e & c, c});
      bus(1'b0, a, 8'h00);
   endtask

   task automatic set_supply(input logic [15:0] mv);
      @(posedge clk_i);
      supply_mv <= mv;
   endtask

   task automatic wait_core(input logic v);
      for (int i = 0; i < 50; i++) begin
         @(posedge clk_i);
         #1;
         if (core_reset_n_o === v) break;
      end
      check("core_reset_n", {7'h0, core_reset_n_o}, {7'h0, v});
      if (core_reset_n_o !== v) conclude();
   endtask

   // Read data stands one cycle after the strobe: compare with oldest note
   always @(posedge clk_i) begin
      if (rd_seen) begin
         note = notes_q.pop_front();
         check(note.name, rdata_o & note.care, note.exp);
      end
      rd_seen <= rd_i;
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      rstn_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; rd_seen = 1'b0; addr_i = 4'h0;
      wdata_i = 8'h00; pin_low_req = 1'b0; supply_mv = 16'h0000; cfg2 = 8'h00; cfg1 = 8'h00;
      errors = 0; n_compared = 0;
      rnd = 8'($urandom(32'h42df9553));
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      check("core_reset_n before rise", {7'h0, core_reset_n_o}, 8'h00);
      set_supply(16'd3300);
      wait_core(1'b1);
      rd(rst_cause_pkg::CAUSE_OFFSET, 8'h00, 8'hff, "cause after power-on");
      rd(rst_cause_pkg::STATUS_OFFSET, 8'h01, 8'h01, "status power-on");
      bus(1'b1, rst_cause_pkg::CAUSE_OFFSET, 8'h03);
      rd(rst_cause_pkg::CAUSE_OFFSET, 8'h03, 8'hff, "cause after write");
      bus(1'b1, rst_cause_pkg::STATUS_OFFSET, 8'h0f);
      rd(4'h9, 8'h00, 8'hff, "unmapped read");
      bus(1'b1, 4'h9, 8'hff);
      rnd = 8'($urandom);
      bus(1'b1, rst_cause_pkg::MASK_OFFSET, rnd);
      rd(rst_cause_pkg::MASK_OFFSET, {4'h0, rnd[3:0]}, 8'hff, "mask readback");
      bus(1'b1, rst_cause_pkg::MASK_OFFSET, 8'h00);
      idle();
      // Short pin glitch is filtered out
      g = 1 + int'($urandom % (FILT - 1));
      for (int i = 0; i < g + 4; i++) begin
         @(posedge clk_i);
         if (i == 0) pin_low_req <= 1'b1;
         if (i == g) pin_low_req <= 1'b0;
         #1;
         check("core_reset_n glitch", {7'h0, core_reset_n_o}, 8'h01);
      end
      rd(rst_cause_pkg::STATUS_OFFSET, 8'h00, 8'h04, "status glitch");
      idle();
      // Long pin low holds reset, pin never driven
      h = FILT + int'($urandom % 8);
      @(posedge clk_i);
      pin_low_req <= 1'b1;
      repeat (h + 2) @(posedge clk_i);
      #1;
      check("core_reset_n pin low", {7'h0, core_reset_n_o}, 8'h00);
      check("pin drive", {6'h0, pin_oe, pin_out}, 8'h00);
      rd(rst_cause_pkg::STATUS_OFFSET, 8'h04, 8'h04, "status pin");
      rd(rst_cause_pkg::SOURCE_OFFSET, 8'h05, 8'hff, "source pin");
      idle();
      #1;
      check("irq masked", {7'h0, irq_o}, 8'h00);
      @(posedge clk_i);
      pin_low_req <= 1'b0;
      wait_core(1'b1);
      bus(1'b1, rst_cause_pkg::MASK_OFFSET, 8'h04);
      idle();
      #1;
      check("irq unmasked", {7'h0, irq_o}, 8'h01);
      bus(1'b1, rst_cause_pkg::STATUS_OFFSET, 8'h04);
      idle();
      #1;
      check("irq cleared", {7'h0, irq_o}, 8'h00);
      bus(1'b1, rst_cause_pkg::MASK_OFFSET, 8'h00);
      // every brown-out power mode, level select equal to mode
      for (int md = 0; md < 4; md++) begin
         rnd = 8'($urandom);
         @(posedge clk_i);
         wr_i <= 1'b0;
         cfg2 <= {rnd[7], 2'(md), rnd[4:0]};
         cfg1 <= {rnd[7:4], 2'(md), rnd[1:0]};
         set_supply(16'(TRIP_MV[md] + 50));
         repeat (6) @(posedge clk_i);
         #1;
         check("core_reset_n above trip", {7'h0, core_reset_n_o}, 8'h01);
         set_supply(16'd1000);
         repeat (6) @(posedge clk_i);
         #1;
         check("core_reset_n below trip", {7'h0, core_reset_n_o}, 8'h00);
         rd(rst_cause_pkg::CAUSE_OFFSET, {7'h01, md >= 2}, 8'h03, "cause drop");
         rd(rst_cause_pkg::STATUS_OFFSET, (md == 3) ? 8'h08 : 8'h0a, (md == 2) ? 8'h08 : 8'h0a,
            "status drop");
         idle();
         set_supply(16'd3300);
         wait_core(1'b1);
         rd(rst_cause_pkg::CAUSE_OFFSET, 8'h00, 8'hff, "cause rise");
         bus(1'b1, rst_cause_pkg::CAUSE_OFFSET, 8'h03);
         bus(1'b1, rst_cause_pkg::STATUS_OFFSET, 8'h0f);
         idle();
      end
      repeat (4) @(posedge clk_i);
      conclude();
   end
endmodule
